// ### design/frd_top.sv
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Device acknowledges all three instruction bytes.
// - Device returns exactly one addressed data byte.
// - Float prescaler divides by four.
// - High prescaler divides by eight.
// - Option two with the low prescaler gives overall division by four.
// - Low prescaler options 3,4,5 divide 12,24,48.
// - High prescaler never yields divide by twelve.
// - Address is 1010, strap bits, then R/W.
// - Receiver pulls data low on ninth clock.
// - Bytes shift most significant bit first.
module frd_top
  import frd_pkg::*;
#(
  parameter int CHANNELS = 4
)(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe_n_o,
  input  wire logic [2:0]            addr_sel_i,
  output logic [7:0]                 reg_addr_o,
  output logic                       rd_strobe_o,
  input  wire logic [7:0]            reg_rdata_i,
  input  wire logic                  reference_clock_in_i,
  input  wire logic [1:0]            prescaler_select_i,
  input  wire logic [4*CHANNELS-1:0] division_option_i,
  output logic [CHANNELS-1:0]        fanout_clock_out_o
);

  // ****************************************************************
  // Pin synchronisers: bit 0 scl, bit 1 sda, bit 2 reference
  // ****************************************************************
  logic [2:0] s1_r, s2_r, s3_r, flt_r, prv_r;
  logic [2:0] flt_nxt;

  always_comb begin
    flt_nxt = flt_r;
    for (int i = 0; i < 3; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        flt_nxt[i] = s3_r[i];
      end
    end
  end

  // Idle-high reset values keep a false start away at power-up.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r  <= FRD_SYNC_RST;
      s2_r  <= FRD_SYNC_RST;
      s3_r  <= FRD_SYNC_RST;
      flt_r <= FRD_SYNC_RST;
      prv_r <= FRD_SYNC_RST;
    end else begin
      s1_r  <= {reference_clock_in_i, sda_i, scl_i};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      flt_r <= flt_nxt;
      prv_r <= flt_r;
    end
  end

  logic scl_rise, scl_fall, start_ev, stop_ev, ref_edge;
  assign scl_rise = flt_r[0] & ~prv_r[0];
  assign scl_fall = ~flt_r[0] & prv_r[0];
  assign start_ev = flt_r[0] & prv_r[0] & ~flt_r[1] & prv_r[1];
  assign stop_ev  = flt_r[0] & prv_r[0] & flt_r[1] & ~prv_r[1];
  assign ref_edge = flt_r[2] & ~prv_r[2];

  // ****************************************************************
  // Strap capture, once after reset release
  // ****************************************************************
  logic [2:0] sel_r;
  logic       sel_ok_r;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_r    <= 3'h0;
      sel_ok_r <= 1'b0;
    end else if (!sel_ok_r) begin
      sel_r    <= addr_sel_i;
      sel_ok_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Serial target state machine
  // ****************************************************************
  frd_state_t st_r, st_nxt, after_r, after_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt, ra_r, ra_nxt;
  logic       drv_r, drv_nxt, got_r, got_nxt, stb_r, stb_nxt;
  logic       match;

  assign match = (rx_r[7:4] == FRD_ADDR_FIXED) && (rx_r[3:1] == sel_r);

  always_comb begin
    st_nxt    = st_r;
    after_nxt = after_r;
    cnt_nxt   = cnt_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    ra_nxt    = ra_r;
    drv_nxt   = drv_r;
    got_nxt   = got_r;
    stb_nxt   = 1'b0;
    if (stop_ev) begin
      st_nxt  = FRD_ST_IDLE;
      drv_nxt = 1'b0;
      got_nxt = 1'b0;
    end else if (start_ev) begin
      // A repeated start keeps the register address for the read.
      st_nxt  = FRD_ST_ADDR;
      cnt_nxt = FRD_BITCNT_RST;
      drv_nxt = 1'b0;
    end else begin
      case (st_r)
        FRD_ST_IDLE: begin
          drv_nxt = 1'b0;
        end
        FRD_ST_ADDR, FRD_ST_REGA: begin
          if (scl_rise && cnt_r < FRD_BITS_BYTE) begin
            rx_nxt  = {rx_r[6:0], flt_r[1]};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == FRD_BITS_BYTE) begin
            st_nxt  = FRD_ST_ACK;
            drv_nxt = 1'b1;
            if (st_r == FRD_ST_REGA) begin
              ra_nxt    = rx_r;
              got_nxt   = 1'b1;
              after_nxt = FRD_ST_IGN;
            end else if (!match) begin
              st_nxt  = FRD_ST_IGN;
              drv_nxt = 1'b0;
            end else if (!rx_r[0]) begin
              after_nxt = FRD_ST_REGA;
            end else if (got_r) begin
              after_nxt = FRD_ST_TX;
            end else begin
              st_nxt  = FRD_ST_IGN;
              drv_nxt = 1'b0;
            end
          end
        end
        FRD_ST_ACK: begin
          if (scl_fall) begin
            st_nxt  = after_r;
            cnt_nxt = FRD_BITCNT_RST;
            drv_nxt = 1'b0;
            if (after_r == FRD_ST_TX) begin
              tx_nxt  = reg_rdata_i;
              drv_nxt = ~reg_rdata_i[7];
              stb_nxt = 1'b1;
            end
          end
        end
        FRD_ST_TX: begin
          if (scl_fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == FRD_TX_LAST) begin
              // Single byte only; the controller's answer is not used.
              st_nxt  = FRD_ST_IGN;
              drv_nxt = 1'b0;
            end else begin
              tx_nxt  = {tx_r[6:0], 1'b0};
              drv_nxt = ~tx_r[6];
            end
          end
        end
        FRD_ST_IGN: begin
          drv_nxt = 1'b0;
        end
        default: begin
          st_nxt  = FRD_ST_IDLE;
          drv_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r    <= FRD_ST_IDLE;
      after_r <= FRD_ST_IGN;
      cnt_r   <= FRD_BITCNT_RST;
      rx_r    <= FRD_BYTE_RST;
      tx_r    <= FRD_BYTE_RST;
      ra_r    <= FRD_BYTE_RST;
      drv_r   <= 1'b0;
      got_r   <= 1'b0;
      stb_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      after_r <= after_nxt;
      cnt_r   <= cnt_nxt;
      rx_r    <= rx_nxt;
      tx_r    <= tx_nxt;
      ra_r    <= ra_nxt;
      drv_r   <= drv_nxt;
      got_r   <= got_nxt;
      stb_r   <= stb_nxt;
    end
  end

  assign sda_o       = 1'b0;
  assign sda_oe_n_o  = ~drv_r;
  assign reg_addr_o  = ra_r;
  assign rd_strobe_o = stb_r;

  // ****************************************************************
  // Output dividers
  // ****************************************************************
  logic [3:0] ratio;
  always_comb begin
    case (prescaler_select_i)
      FRD_PRE_LOW:   ratio = FRD_RATIO_LOW;
      FRD_PRE_FLOAT: ratio = FRD_RATIO_FLOAT;
      FRD_PRE_HIGH:  ratio = FRD_RATIO_HIGH;
      default:       ratio = FRD_RATIO_HIGH;
    endcase
  end

  // Ratios are even, so the half period is always a whole count.
  logic [FRD_DIV_W-1:0] half [CHANNELS];
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      logic [10:0] prod;
      assign prod = 11'(ratio * FRD_OPT_DIV[division_option_i[4*g +: 4]]);
      assign half[g] = prod[FRD_DIV_W:1];
      frd_div_chan u_div (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .ref_edge_i (ref_edge),
        .half_i     (half[g]),
        .clk_o      (fanout_clock_out_o[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic dec_addr;
  assign dec_addr = (st_r == FRD_ST_ADDR) && scl_fall && !start_ev
                    && !stop_ev && (cnt_r == FRD_BITS_BYTE);

  a_ack_write_addr: assert property (
    dec_addr && match && !rx_r[0] |=> drv_r && st_r == FRD_ST_ACK)
    else $error("write-phase address not acknowledged");
  a_ignore_mismatch: assert property (
    dec_addr && !match |=> !drv_r && st_r == FRD_ST_IGN)
    else $error("mismatched address not ignored");
  a_read_needs_reg: assert property (
    dec_addr && match && rx_r[0] && !got_r |=> !drv_r)
    else $error("read acknowledged without register address");
  a_msb_first_out: assert property (
    $rose(stb_r) |-> drv_r == ~tx_r[7] && st_r == FRD_ST_TX)
    else $error("data byte not started with its top bit");
  a_single_byte: assert property (
    st_r == FRD_ST_TX && scl_fall && !start_ev && !stop_ev
    && cnt_r == FRD_TX_LAST |=> !drv_r && st_r == FRD_ST_IGN)
    else $error("line not released after one data byte");
  a_stop_release: assert property (
    stop_ev |=> !drv_r && st_r == FRD_ST_IDLE && !got_r)
    else $error("stop did not return to idle");
  a_low_options: assert property (
    prescaler_select_i == FRD_PRE_LOW && division_option_i[3:0] == 4'h4
    |-> half[0] == 10'h00C)
    else $error("low prescaler option 4 not divide by 24");
  a_high_no_twelve: assert property (
    prescaler_select_i == FRD_PRE_HIGH |-> half[0] != 10'h006)
    else $error("high prescaler produced divide by 12");

  c_read_byte: cover property ($rose(stb_r) ##[1:300] stop_ev);
  c_addr_mismatch: cover property (dec_addr && !match);
  c_repeated_start: cover property (got_r && start_ev);
  c_chan_toggle: cover property ($rose(fanout_clock_out_o[0]));

endmodule : frd_top
`default_nettype wire

// ### inc/frd_pkg.sv
package frd_pkg;

  // ****************************************************************
  // Serial target addressing
  // ****************************************************************
  localparam logic [3:0] FRD_ADDR_FIXED = 4'hA;
  localparam logic [3:0] FRD_BITCNT_RST = 4'h0;
  localparam logic [3:0] FRD_BITS_BYTE  = 4'h8;
  localparam logic [3:0] FRD_TX_LAST    = 4'h7;
  localparam logic [7:0] FRD_BYTE_RST   = 8'h00;
  localparam logic [2:0] FRD_SYNC_RST   = 3'h7;

  // ****************************************************************
  // Prescaler encodings and ratios
  // ****************************************************************
  localparam logic [1:0] FRD_PRE_LOW   = 2'h0;
  localparam logic [1:0] FRD_PRE_FLOAT = 2'h1;
  localparam logic [1:0] FRD_PRE_HIGH  = 2'h2;
  localparam logic [3:0] FRD_RATIO_LOW   = 4'h2;
  localparam logic [3:0] FRD_RATIO_FLOAT = 4'h4;
  localparam logic [3:0] FRD_RATIO_HIGH  = 4'h8;

  // ****************************************************************
  // Per-option channel divisor; zero holds the channel low
  // ****************************************************************
  localparam int FRD_DIV_W = 10;
  localparam logic [6:0] FRD_OPT_DIV [0:15] = '{
    7'h01, 7'h01, 7'h02, 7'h06, 7'h0C, 7'h18, 7'h30, 7'h60,
    7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00};
  localparam logic [FRD_DIV_W-1:0] FRD_CNT_RST = 10'h000;

  typedef enum logic [5:0] {
    FRD_ST_IDLE = 6'b000001,
    FRD_ST_ADDR = 6'b000010,
    FRD_ST_REGA = 6'b000100,
    FRD_ST_ACK  = 6'b001000,
    FRD_ST_TX   = 6'b010000,
    FRD_ST_IGN  = 6'b100000
  } frd_state_t;

endpackage : frd_pkg

// ### design/frd_div_chan.sv
`timescale 1ns/1ps
`default_nettype none
module frd_div_chan
  import frd_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  input  wire logic                 ref_edge_i,
  input  wire logic [FRD_DIV_W-1:0] half_i,
  output logic                      clk_o
);

  logic [FRD_DIV_W-1:0] cnt_r;
  logic [FRD_DIV_W-1:0] cnt_nxt;
  logic                 out_r;
  logic                 out_nxt;

  // ****************************************************************
  // Half-period counter on reference rising edges
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (half_i == FRD_CNT_RST) begin
      cnt_nxt = FRD_CNT_RST;
      out_nxt = 1'b0;
    end else if (ref_edge_i) begin
      if (cnt_r + 10'h001 >= half_i) begin
        cnt_nxt = FRD_CNT_RST;
        out_nxt = ~out_r;
      end else begin
        cnt_nxt = cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= FRD_CNT_RST;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign clk_o = out_r;

endmodule : frd_div_chan
`default_nettype wire

// ### tb/frd_i2c_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module frd_i2c_ctrl (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ****************************************************************
  // Bus controller
  // ****************************************************************
  // Eight cycles a phase keep every level well past the pin filter.
  localparam int QTR = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold();
    repeat (QTR) @(negedge clk_sys_i);
  endtask : hold
  task automatic start();
    sda_o = 1'b1;
    hold();
    scl_o = 1'b1;
    hold();
    sda_o = 1'b0;
    hold();
    scl_o = 1'b0;
    hold();
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    hold();
    scl_o = 1'b1;
    hold();
    sda_o = 1'b1;
    hold();
  endtask : stop
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    hold();
    scl_o = 1'b1;
    hold();
    r = sda_i;
    hold();
    scl_o = 1'b0;
    hold();
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask : rd_byte
  // A second byte is clocked only to show the line stays released.
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra,
                          input logic two, output logic [2:0] acks,
                          output logic [7:0] d0, output logic [7:0] d1);
    start();
    wr_byte({dev, 1'b0}, acks[2]);
    wr_byte(ra, acks[1]);
    start();
    wr_byte({dev, 1'b1}, acks[0]);
    rd_byte(two, d0);
    d1 = 8'hFF;
    if (two) begin
      rd_byte(1'b0, d1);
    end
    stop();
  endtask : read_reg
endmodule : frd_i2c_ctrl
`default_nettype wire

// ### tb/tb_fanout_i2c_read_and_divider_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fanout_i2c_read_and_divider_cfg;
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        scl;
  logic        ctl_sda;
  logic        sda_drv;
  logic        sda_oe_n;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_rdata = 8'h00;
  logic        ref_clk   = 1'b0;
  logic [1:0]  rc        = 2'h0;
  logic [1:0]  pre       = 2'h0;
  logic [15:0] opt       = 16'h5234;
  logic [2:0]  strap     = 3'h5;
  logic        stb;
  int          stbs      = 0;
  logic [3:0]  fan;
  logic        seen      = 1'b0;
  int          refs      = 0;
  int          cyc       = 0;
  int          mismatches = 0;
  int          compares  = 0;
  // The line has a pull-up, so a released bus reads high.
  wire logic   sda_bus   = ctl_sda & (sda_oe_n | sda_drv);
  logic [6:0]  dv_t [4]  = '{7'h55, 7'h55, 7'h52, 7'h5D};
  logic [7:0]  ra_t [4]  = '{8'hC3, 8'h81, 8'h7E, 8'h7E};
  logic [1:0]  pre_t [3] = '{2'h0, 2'h1, 2'h2};
  logic [15:0] opt_t [3] = '{16'h5234, 16'h6543, 16'h4321};
  logic [7:0]  exp_t [3][4] = '{'{8'h18, 8'h0C, 8'h04, 8'h30},
                                '{8'h18, 8'h30, 8'h60, 8'hC0},
                                '{8'h08, 8'h10, 8'h30, 8'h60}};

  frd_top u_frd_top (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .scl_i                (scl),
    .sda_i                (sda_bus),
    .sda_o                (sda_drv),
    .sda_oe_n_o           (sda_oe_n),
    .addr_sel_i           (strap),
    .reg_addr_o           (reg_addr),
    .rd_strobe_o          (stb),
    .reg_rdata_i          (reg_rdata),
    .reference_clock_in_i (ref_clk),
    .prescaler_select_i   (pre),
    .division_option_i    (opt),
    .fanout_clock_out_o   (fan)
  );
  frd_i2c_ctrl u_frd_i2c_ctrl (
    .clk_sys_i (clk_sys_i),
    .sda_i     (sda_bus),
    .scl_o     (scl),
    .sda_o     (ctl_sda)
  );

  always #2.5 clk_sys_i = ~clk_sys_i;
  // Three cycles a level: slow enough for the three-flop pin filter.
  always @(negedge clk_sys_i) begin
    rc <= (rc == 2'h2) ? 2'h0 : rc + 2'h1;
    if (rc == 2'h2) begin
      ref_clk <= ~ref_clk;
    end
    reg_rdata <= {reg_addr[3:0], reg_addr[7:4]};
    if (stb === 1'b1) begin
      stbs <= stbs + 1;
    end
  end
  always @(posedge ref_clk) refs++;
  always @(posedge clk_sys_i) begin
    if (sda_oe_n === 1'b0) begin
      seen = 1'b1;
    end
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Reference edges between the second and third rise of one channel.
  task automatic meas(input int ch, output int n);
    logic p;
    int   e;
    int   k;
    e = 0;
    k = 0;
    n = 0;
    p = fan[ch];
    while (e < 3 && k < 5000) begin
      @(negedge clk_sys_i);
      k++;
      if (fan[ch] === 1'b1 && p === 1'b0) begin
        e++;
        n = (e == 2) ? refs : refs - n;
      end
      p = fan[ch];
    end
  endtask : meas

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    logic [2:0] acks;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] ra;
    logic       ok;
    int         n;
    repeat (6) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      ra = ra_t[i];
      ok = (i < 2);
      seen = 1'b0;
      u_frd_i2c_ctrl.read_reg(dv_t[i], ra, i == 0, acks, d0, d1);
      chk({5'h0, acks}, ok ? 8'h07 : 8'h00);
      chk(d0, ok ? {ra[3:0], ra[7:4]} : 8'hFF);
      chk(d1, 8'hFF);
      chk(reg_addr, ok ? ra : 8'h81);
      chk({7'h0, seen}, {7'h0, ok});
    end
    // Refused requests: a read with no register address, then write data.
    u_frd_i2c_ctrl.start();
    u_frd_i2c_ctrl.wr_byte(8'hAB, ok);
    chk({7'h0, ok}, 8'h00);
    u_frd_i2c_ctrl.stop();
    u_frd_i2c_ctrl.start();
    u_frd_i2c_ctrl.wr_byte(8'hAA, acks[2]);
    u_frd_i2c_ctrl.wr_byte(8'h3C, acks[1]);
    u_frd_i2c_ctrl.wr_byte(8'h99, acks[0]);
    u_frd_i2c_ctrl.stop();
    chk({5'h0, acks}, 8'h06);
    chk(reg_addr, 8'h3C);
    // A second reset takes a new strap value for the address match.
    rst_i = 1'b1;
    strap = 3'h2;
    repeat (2) @(negedge clk_sys_i);
    chk({fan, 3'h0, sda_oe_n}, 8'h01);
    chk(reg_addr, 8'h00);
    rst_i = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    u_frd_i2c_ctrl.read_reg(7'h52, 8'h5A, 1'b0, acks, d0, d1);
    chk({5'h0, acks}, 8'h07);
    chk(d0, 8'hA5);
    u_frd_i2c_ctrl.read_reg(7'h55, 8'h5A, 1'b0, acks, d0, d1);
    chk({5'h0, acks}, 8'h00);
    chk(d0, 8'hFF);
    chk(8'(stbs), 8'h03);
    for (int r = 0; r < 3; r++) begin
      pre = pre_t[r];
      opt = opt_t[r];
      for (int c = 0; c < 4; c++) begin
        meas(c, n);
        chk(8'(n), exp_t[r][c]);
      end
    end
    end_sim();
  end
endmodule : tb_fanout_i2c_read_and_divider_cfg
`default_nettype wire
